// File: hdl/src_pkg.sv
/*
  constants, carrier structs and the restore-list decoder for the soft reset control block.
  assumes a byte-wide register access port fed by the serial control bus slave.
*/
// Functional notes
// - video-input reset bit pulses block reset, self-clears
// - bit 1 resets whole core with registers
// - bridge bit after full reset restores memory defaults
// - bit 0 resets core but keeps registers
// - core-only reset reloads strap-derived registers
// - core-only reset restores listed register defaults
// - general config bit 7 enables CRC check
`default_nettype none
package src_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_DEVICE_ID  = 8'h00;  // strap-loaded address register
  localparam logic [7:0] OFF_RESET_CMD  = 8'h01;  // reset_command
  localparam logic [7:0] OFF_GEN_CFG    = 8'h03;  // general_config
  localparam logic [7:0] OFF_BRIDGE_CONTROL_REG = 8'h4F;  // bridge_control_reg, held elsewhere

  localparam logic [7:0] RST_CMD_RESET  = 8'h00;  // reset_command default
  localparam logic [7:0] GEN_CFG_RESET  = 8'hD2;  // general_config default
  localparam logic [7:0] RST_CMD_MASK   = 8'h13;  // implemented reset_command bits

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_VID_RST    = 4;  // video-input digital reset
  localparam int BIT_FULL_RST   = 1;  // full_core_reset
  localparam int BIT_KEEP_RST   = 0;  // core_reset_keep_regs
  localparam int BIT_CRC_EN     = 7;  // back-channel crc check enable
  localparam int BIT_BRIDGE_NVM = 1;  // bridge_control_reg restore bit

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 8000;  // ref_clk at 125 MHz
  localparam int RST_PULSE_NS   = 64;    // least width of each reset pulse
  localparam int RST_PULSE_CYC  = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STRAP_SYNC_CYC = 2;     // synchroniser depth before strap capture
  localparam int NUM_RST        = 3;     // reset kinds
  localparam int IDX_VID        = 0;
  localparam int IDX_FULL       = 1;
  localparam int IDX_KEEP       = 2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;     // one-cycle write strobe
    logic       rd;     // one-cycle read strobe
    logic [7:0] addr;   // register offset
    logic [7:0] wdata;  // write byte
  } src_reg_req_t;

  typedef struct packed {
    logic       video_in_reset;        // video-input block reset level
    logic       full_core_reset;       // core reset including registers
    logic       core_reset_keep_regs;  // core reset, registers kept
    logic       nvm_restore;           // one-cycle restore of memory-loaded defaults
    logic       strap_reload;          // one-cycle reload of strap registers
    logic       restore_dflt;          // one-cycle restore of listed registers
    logic [6:0] strap_value;           // originally strapped address
    logic       crc_check_en;          // back-channel crc check enable
    logic [7:0] gen_cfg;               // whole general_config byte
  } src_rst_out_t;

  // registers returned to default by the core-only reset
  function automatic logic src_restored_by_keep(input logic [7:0] a);
    logic hit;
    hit = (a >= 8'h48) && (a <= 8'h55);
    unique case (a)
      8'h00, 8'h13, 8'h15, 8'h18, 8'h19, 8'h1A, 8'h58, 8'h5B,
      8'hC0, 8'hC2, 8'hC3, 8'hC6, 8'hC8, 8'hCE, 8'hD0: hit = 1'b1;
      default: hit = hit;
    endcase
    return hit;
  endfunction

endpackage
`default_nettype wire

// File: hdl/src_pulse_gen.sv
/*
  fixed-length reset pulse generator, one per reset command bit.
  assumes start is a one-cycle strobe from logic on the same clock.
*/
`default_nettype none
module src_pulse_gen #(
  parameter int LEN = 8  // pulse length in cycles
) (
  input  wire logic ref_clk,  // block clock
  input  wire logic resetn,   // async reset, active low
  input  wire logic start,    // begin a pulse
  output var  logic active    // pulse level, from a flop
);
  localparam int CW = $clog2(LEN + 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic          on;   // pulse running
    logic [CW-1:0] cnt;  // cycles left
  } src_pg_state_t;

  src_pg_state_t st;       // registered state
  src_pg_state_t next_st;  // next state

  // count down, restart ignored while running
  always_comb begin
    next_st = st;
    if (st.on) begin
      next_st.cnt = st.cnt - CW'(1);
      if (st.cnt == CW'(1)) begin
        next_st.on = 1'b0;
      end
    end else if (start) begin
      next_st.on  = 1'b1;
      next_st.cnt = CW'(LEN);
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign active = st.on;
endmodule
`default_nettype wire

// File: hdl/src_soft_reset_control.sv
/*
  soft reset control: reset_command and general_config registers, reset pulse
  generation, strap capture and restore strobes for the rest of the core.
  assumes the serial control bus slave presents decoded byte accesses on req,
  and that the registers named by the restore strobes live outside this block.
*/
`default_nettype none
module src_soft_reset_control
  import src_pkg::*;
#(
  parameter int PULSE_LEN = RST_PULSE_CYC  // reset pulse length in cycles
) (
  input  wire logic         ref_clk,       // 125 MHz clock
  input  wire logic         resetn,        // power-on reset, active low
  input  wire src_reg_req_t req,           // register access request
  input  wire logic [6:0]   strap_id_pin,  // address strap pins
  output var  logic [7:0]   reg_rdata,     // read byte, from a flop
  output var  logic         reg_rvalid,    // read byte valid, one cycle
  output var  src_rst_out_t rst_out        // reset and config outputs
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] gen_cfg;       // general_config
    logic [7:0] rdata;         // read data register
    logic       rvalid;        // read answer strobe
    logic       full_seen;     // full reset started, bridge bit awaited
    logic       nvm_restore;   // restore strobe
    logic       strap_reload;  // strap reload strobe
    logic       restore_dflt;  // listed-register restore strobe
    logic [6:0] sync1;         // strap synchroniser stage 1
    logic [6:0] sync2;         // strap synchroniser stage 2
    logic [6:0] strap_id;      // strap captured after reset
    logic [1:0] strap_age;     // cycles since reset release
  } src_state_t;

  src_state_t         st;       // registered state
  src_state_t         next_st;  // next state
  logic [NUM_RST-1:0] start;    // pulse start strobes
  logic [NUM_RST-1:0] active;   // pulse levels
  logic [7:0]         cmd_rd;   // reset_command readback
  logic               wr_cmd;   // write to reset_command
  logic               wr_cfg;   // write to general_config
  logic               wr_brg;   // write to bridge_control_reg

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign wr_cmd = req.wr && (req.addr == OFF_RESET_CMD);
  assign wr_cfg = req.wr && (req.addr == OFF_GEN_CFG);
  assign wr_brg = req.wr && (req.addr == OFF_BRIDGE_CONTROL_REG);

  // a one starts a pulse unless that pulse already runs
  assign start[IDX_VID]  = wr_cmd && req.wdata[BIT_VID_RST]  && !active[IDX_VID];
  assign start[IDX_FULL] = wr_cmd && req.wdata[BIT_FULL_RST] && !active[IDX_FULL];
  assign start[IDX_KEEP] = wr_cmd && req.wdata[BIT_KEEP_RST] && !active[IDX_KEEP];

  // command bits read one while their pulse runs, reserved bits zero
  always_comb begin
    cmd_rd               = 8'h00;
    cmd_rd[BIT_VID_RST]  = active[IDX_VID];
    cmd_rd[BIT_FULL_RST] = active[IDX_FULL];
    cmd_rd[BIT_KEEP_RST] = active[IDX_KEEP];
  end

  // ---------------------------------------------------------------
  // pulse generators
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_RST; i++) begin : g_pulse
    src_pulse_gen #(
      .LEN (PULSE_LEN)
    ) u_pulse (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .start   (start[i]),
      .active  (active[i])
    );
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st              = st;
    next_st.rvalid       = req.rd;
    next_st.nvm_restore  = 1'b0;
    next_st.strap_reload = 1'b0;
    next_st.restore_dflt = 1'b0;
    // strap synchroniser and capture after release
    next_st.sync1        = strap_id_pin;
    next_st.sync2        = st.sync1;
    if (st.strap_age != 2'(STRAP_SYNC_CYC + 1)) begin
      next_st.strap_age = st.strap_age + 2'(1);
    end
    if (st.strap_age == 2'(STRAP_SYNC_CYC)) begin
      next_st.strap_id = st.sync2;
    end
    // config writes, blocked while registers are held in reset
    if (wr_cfg && !active[IDX_FULL]) begin
      next_st.gen_cfg = req.wdata;
    end
    // full reset returns registers to defaults
    if (start[IDX_FULL]) begin
      next_st.gen_cfg   = GEN_CFG_RESET;
      next_st.full_seen = 1'b1;
    end else if (wr_brg && req.wdata[BIT_BRIDGE_NVM] && st.full_seen) begin
      next_st.nvm_restore = 1'b1;
      next_st.full_seen   = 1'b0;
    end
    // core-only reset keeps registers except straps and the listed set
    if (start[IDX_KEEP]) begin
      next_st.strap_reload = 1'b1;
      next_st.restore_dflt = 1'b1;
      if (src_restored_by_keep(OFF_GEN_CFG)) begin
        next_st.gen_cfg = GEN_CFG_RESET;
      end
    end
    // read mux, unmapped offsets answer zero
    if (req.rd) begin
      unique case (req.addr)
        OFF_RESET_CMD: next_st.rdata = cmd_rd;
        OFF_GEN_CFG:   next_st.rdata = st.gen_cfg;
        default:       next_st.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st         <= '0;
      st.gen_cfg <= GEN_CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata                    = st.rdata;
  assign reg_rvalid                   = st.rvalid;
  // one driver for the whole carrier
  assign rst_out = '{
    video_in_reset:       active[IDX_VID],
    full_core_reset:      active[IDX_FULL],
    core_reset_keep_regs: active[IDX_KEEP],
    nvm_restore:          st.nvm_restore,
    strap_reload:         st.strap_reload,
    restore_dflt:         st.restore_dflt,
    strap_value:          st.strap_id,
    crc_check_en:         st.gen_cfg[BIT_CRC_EN],
    gen_cfg:              st.gen_cfg
  };

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  localparam int PULSE_LAST = PULSE_LEN - 1;  // cycles after the rising one

  // pulse stands PULSE_LEN cycles for any parameter value
  vid_pulse_len_a: assert property (
    $rose(rst_out.video_in_reset)
      |-> (rst_out.video_in_reset throughout (##PULSE_LAST 1'b1)) ##1 !rst_out.video_in_reset)
    else $error("video reset pulse length wrong");

  full_start_a: assert property (
    (wr_cmd && req.wdata[BIT_FULL_RST] && !rst_out.full_core_reset)
      |=> rst_out.full_core_reset && (rst_out.gen_cfg == GEN_CFG_RESET))
    else $error("full reset did not start with defaults");

  nvm_after_full_a: assert property (
    (wr_brg && req.wdata[BIT_BRIDGE_NVM] && st.full_seen && !start[IDX_FULL])
      |=> rst_out.nvm_restore ##1 !rst_out.nvm_restore)
    else $error("bridge bit did not restore defaults");

  keep_regs_a: assert property (
    (wr_cmd && req.wdata[BIT_KEEP_RST] && !req.wdata[BIT_FULL_RST] && !active[IDX_KEEP]
      && !active[IDX_FULL]) |=> rst_out.core_reset_keep_regs
      && (rst_out.gen_cfg == $past(rst_out.gen_cfg)))
    else $error("core-only reset disturbed config");

  strap_reload_a: assert property (
    $rose(rst_out.core_reset_keep_regs) |-> rst_out.strap_reload)
    else $error("strap reload missing");

  // strapped value is captured once and never follows later pin moves
  strap_hold_a: assert property (
    (st.strap_age == 2'(STRAP_SYNC_CYC + 1)) |=> $stable(rst_out.strap_value))
    else $error("strapped value changed after capture");

  restore_pulse_a: assert property (
    $rose(rst_out.core_reset_keep_regs) |-> rst_out.restore_dflt ##1 !rst_out.restore_dflt)
    else $error("listed register restore missing");

  crc_enable_a: assert property (
    (wr_cfg && !rst_out.full_core_reset && !start[IDX_FULL] && !start[IDX_KEEP])
      |=> rst_out.crc_check_en == $past(req.wdata[BIT_CRC_EN]))
    else $error("crc enable not following bit 7");

  rsvd_zero_a: assert property (
    (req.rd && req.addr == OFF_RESET_CMD)
      |=> reg_rvalid && ((reg_rdata & ~RST_CMD_MASK) == 8'h00))
    else $error("reserved reset bits not zero");

  self_clear_a: assert property (
    (req.rd && req.addr == OFF_RESET_CMD)
      |=> reg_rdata[BIT_FULL_RST] == $past(rst_out.full_core_reset))
    else $error("full reset bit did not clear");

endmodule
`default_nettype wire

// File: testbench/src_host_model.sv
/*
  host model on the register request port of the soft reset control block.
  assumes the design takes one request at a rising edge of ref_clk.
*/
`default_nettype none
module src_host_model
  import src_pkg::*;
(
  input  wire logic         ref_clk,     // block clock
  input  wire logic [7:0]   reg_rdata,   // read byte
  input  wire logic         reg_rvalid,  // read answer strobe
  output var  src_reg_req_t req          // request to the design
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  initial req = '0;

  // one request from a falling edge, held over the taking edge;
  // idle address and data are inverted so stale values never match
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // write one byte, issued as a single request cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask

  // full reset, then the bridge restore bit as software should
  task automatic full_reset_then_bridge();
    wr(OFF_RESET_CMD, 8'h02);
    wr(OFF_BRIDGE_CONTROL_REG, 8'h02);
  endtask

  // read one byte, waiting a bounded count for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    int n;
    put(1'b0, a, 8'h00);
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    q = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule
`default_nettype wire

// File: testbench/src_soft_reset_control_tb.sv
/*
  self-checking bench for the soft reset control block.
  assumes the host model drives the request port; strap pins come from here.
*/
`default_nettype none
module src_soft_reset_control_tb
  import src_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PL = 6;  // shortened pulse length

  logic         ref_clk = 1'b0;  // 125 MHz clock
  logic         resetn  = 1'b0;  // power-on reset, active low
  logic [6:0]   strap_id_pin;    // strap pins
  logic [6:0]   strap0;          // value strapped at power-up
  logic [7:0]   reg_rdata;       // read byte
  logic         reg_rvalid;      // read strobe
  src_reg_req_t req;             // request from host
  src_rst_out_t rst_out;         // reset outputs
  logic [7:0]   q;               // read result
  logic [7:0]   v;               // config value
  int           n_mismatch = 0;  // mismatches
  int           tests_run  = 0;  // comparisons
  int           cyc        = 0;  // timeout counter
  int           hi[3]      = '{0, 0, 0};  // cycles each pulse was seen high
  int           k0;              // snapshot of hi

  always #4 ref_clk = ~ref_clk;

  src_soft_reset_control #(.PULSE_LEN(PL)) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .req(req), .strap_id_pin(strap_id_pin),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rst_out(rst_out));

  src_host_model host (
    .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .req(req));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // pulse output by kind: video, full, keep-regs
  function automatic logic pulse(input int i);
    if (i == 0) return rst_out.video_in_reset;
    if (i == 1) return rst_out.full_core_reset;
    return rst_out.core_reset_keep_regs;
  endfunction

  // command bit of each kind
  function automatic logic [7:0] bit_of(input int i);
    return (i == 0) ? 8'h10 : ((i == 1) ? 8'h02 : 8'h01);
  endfunction

  // count high cycles of every pulse
  always @(negedge ref_clk) begin
    for (int i = 0; i < 3; i++) if (pulse(i) === 1'b1) hi[i]++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(56));
    strap_id_pin = 7'($urandom);
    strap0 = strap_id_pin;
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    // defaults after power-up
    chk(rst_out.gen_cfg, 8'hD2);
    chk(rst_out.crc_check_en, 1'b1);
    chk({rst_out.video_in_reset, rst_out.full_core_reset, rst_out.core_reset_keep_regs}, 8'h00);
    chk(rst_out.strap_value, strap0);
    host.rd(OFF_RESET_CMD, q);
    chk(q, 8'h00);
    host.rd(8'h7E, q);
    chk(q, 8'h00);
    // bridge bit with no full reset before it: no restore
    host.wr(OFF_BRIDGE_CONTROL_REG, 8'h02);
    chk(rst_out.nvm_restore, 1'b0);
    strap_id_pin = ~strap0;  // later pin moves must not alter the strap
    // config writes: corners, then random
    for (int j = 0; j < 6; j++) begin
      v = (j == 0) ? 8'h00 : ((j == 1) ? 8'hFF : 8'($urandom));
      host.wr(OFF_GEN_CFG, v);
      chk(rst_out.gen_cfg, v);
      chk(rst_out.crc_check_en, v[7]);
      host.rd(OFF_GEN_CFG, q);
      chk(q, v);
    end
    // each kind, reserved bits set, restart refused mid-pulse
    for (int i = 0; i < 3; i++) begin
      host.wr(OFF_GEN_CFG, 8'h4B);
      k0 = hi[i];
      host.wr(OFF_RESET_CMD, bit_of(i) | 8'hEC);
      chk(rst_out.strap_reload, i == 2);
      chk(rst_out.restore_dflt, i == 2);
      chk(rst_out.strap_value, strap0);
      chk(rst_out.gen_cfg, (i == 1) ? 8'hD2 : 8'h4B);
      // config write during the pulse: refused only while registers are in reset
      host.wr(OFF_GEN_CFG, 8'h5A);
      chk(rst_out.gen_cfg, (i == 1) ? 8'hD2 : 8'h5A);
      host.wr(OFF_RESET_CMD, bit_of(i));
      chk(rst_out.strap_reload, 1'b0);
      host.rd(OFF_RESET_CMD, q);
      chk(q, bit_of(i));
      repeat (PL + 2) @(negedge ref_clk);
      chk(8'(hi[i] - k0), 8'(PL));
      host.rd(OFF_RESET_CMD, q);
      chk(q, 8'h00);
    end
    // bridge bit after a full reset: one restore strobe
    host.full_reset_then_bridge();
    chk(rst_out.nvm_restore, 1'b1);
    @(negedge ref_clk);
    chk(rst_out.nvm_restore, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
